// ==== design/jidb_pkg.sv ====
/*
 * Shared constants and types for the test-port identification, bypass
 * and design-security block.
 * Assumes a single system clock domain; the test clock is sampled.
 */
package jidb_pkg;

    // Instruction register length and its fixed capture pattern.
    localparam int IR_LEN = 10;
    localparam logic [IR_LEN-1:0] IR_CAPTURE = 10'h001;

    // Identification word layout, most significant field first.
    localparam int ID_LEN = 32;
    localparam int ID_VER_W = 4;
    localparam int ID_PART_W = 16;
    localparam int ID_MFR_W = 11;
    localparam int ID_VER_LSB = 28;
    localparam int ID_PART_LSB = 12;
    localparam int ID_MFR_LSB = 1;
    localparam logic ID_FIXED_BIT = 1'b1;

    // Neutral identity defaults; the values are arbitrary.
    localparam logic [ID_VER_W-1:0] DEF_VERSION = 4'h1;
    localparam logic [ID_PART_W-1:0] DEF_PART = 16'hA5C3;
    localparam logic [ID_MFR_W-1:0] DEF_MFR = 11'h2B4;

    // Instruction opcodes.
    localparam logic [IR_LEN-1:0] OP_EXTEST = 10'h000;
    localparam logic [IR_LEN-1:0] OP_SAMPLE = 10'h055;
    localparam logic [IR_LEN-1:0] OP_DEVICE_IDENTIFICATION_WORD = 10'h059;
    localparam logic [IR_LEN-1:0] OP_CFG_READ = 10'h205;
    localparam logic [IR_LEN-1:0] OP_CFG_PROG = 10'h203;
    localparam logic [IR_LEN-1:0] OP_CFG_SECURE = 10'h20F;
    localparam logic [IR_LEN-1:0] OP_CFG_ERASE = 10'h2F2;
    localparam logic [IR_LEN-1:0] OP_BYPASS = 10'h3FF;

    // Reset value of the stored configuration word (blank part).
    localparam logic [ID_LEN-1:0] CFG_BLANK = 32'h0000_0000;

    // Test access port controller states, one-hot.
    typedef enum logic [15:0] {
        TAP_RESET = 16'h0001,
        TAP_IDLE = 16'h0002,
        TAP_SEL_DR = 16'h0004,
        TAP_CAP_DR = 16'h0008,
        TAP_SH_DR = 16'h0010,
        TAP_EX1_DR = 16'h0020,
        TAP_PAU_DR = 16'h0040,
        TAP_EX2_DR = 16'h0080,
        TAP_UPD_DR = 16'h0100,
        TAP_SEL_IR = 16'h0200,
        TAP_CAP_IR = 16'h0400,
        TAP_SH_IR = 16'h0800,
        TAP_EX1_IR = 16'h1000,
        TAP_PAU_IR = 16'h2000,
        TAP_EX2_IR = 16'h4000,
        TAP_UPD_IR = 16'h8000
    } jidb_tap_t;

endpackage

// ==== design/jidb_top.sv ====
/*
 * Test-port identification, bypass and design-security logic.
 * Assumes the test clock, mode select and data input arrive from pins,
 * asynchronous to sys_clk and slower than a quarter of its rate.
 */
`timescale 1ns/1ps
module jidb_top #(
    parameter logic [jidb_pkg::ID_VER_W-1:0] VERSION = jidb_pkg::DEF_VERSION,
    parameter logic [jidb_pkg::ID_PART_W-1:0] PART = jidb_pkg::DEF_PART,
    parameter logic [jidb_pkg::ID_MFR_W-1:0] MFR = jidb_pkg::DEF_MFR
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    output logic tdo,
    output logic tdo_oe_n,
    output logic secure_ff,
    output logic [jidb_pkg::ID_LEN-1:0] cfg_ff
);
    import jidb_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers and test clock edge detection.
    ////////////////////////////////////////////////////////////////////////

    logic [1:0] tck_sync_ff; // Two-stage test clock synchroniser.
    logic [1:0] tms_sync_ff; // Two-stage mode select synchroniser.
    logic [1:0] tdi_sync_ff; // Two-stage data input synchroniser.
    logic tck_last_ff; // Previous synchronised test clock level.
    logic tck_rise; // One cycle pulse on a test clock rising edge.
    logic tck_fall; // One cycle pulse on a test clock falling edge.

    // The first stage of each chain feeds only its second stage.
    // The test clock chain resets to its resting high level, so leaving
    // reset never shows a false edge.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tck_sync_ff <= 2'h3;
            tms_sync_ff <= 2'h3;
            tdi_sync_ff <= 2'h0;
            tck_last_ff <= 1'b1;
        end else begin
            tck_sync_ff <= {tck_sync_ff[0], tck};
            tms_sync_ff <= {tms_sync_ff[0], tms};
            tdi_sync_ff <= {tdi_sync_ff[0], tdi};
            tck_last_ff <= tck_sync_ff[1];
        end
    end

    assign tck_rise = tck_sync_ff[1] & ~tck_last_ff;
    assign tck_fall = ~tck_sync_ff[1] & tck_last_ff;

    ////////////////////////////////////////////////////////////////////////
    // Controller state machine.
    ////////////////////////////////////////////////////////////////////////

    jidb_tap_t state_ff; // Current controller state.
    jidb_tap_t nxt_state; // State taken at the next test clock rise.

    // Standard sixteen-state walk steered by the mode select level.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            TAP_RESET: nxt_state = tms_sync_ff[1] ? TAP_RESET : TAP_IDLE;
            TAP_IDLE: nxt_state = tms_sync_ff[1] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_DR: nxt_state = tms_sync_ff[1] ? TAP_SEL_IR : TAP_CAP_DR;
            TAP_CAP_DR: nxt_state = tms_sync_ff[1] ? TAP_EX1_DR : TAP_SH_DR;
            TAP_SH_DR: nxt_state = tms_sync_ff[1] ? TAP_EX1_DR : TAP_SH_DR;
            TAP_EX1_DR: nxt_state = tms_sync_ff[1] ? TAP_UPD_DR : TAP_PAU_DR;
            TAP_PAU_DR: nxt_state = tms_sync_ff[1] ? TAP_EX2_DR : TAP_PAU_DR;
            TAP_EX2_DR: nxt_state = tms_sync_ff[1] ? TAP_UPD_DR : TAP_SH_DR;
            TAP_UPD_DR: nxt_state = tms_sync_ff[1] ? TAP_SEL_DR : TAP_IDLE;
            TAP_SEL_IR: nxt_state = tms_sync_ff[1] ? TAP_RESET : TAP_CAP_IR;
            TAP_CAP_IR: nxt_state = tms_sync_ff[1] ? TAP_EX1_IR : TAP_SH_IR;
            TAP_SH_IR: nxt_state = tms_sync_ff[1] ? TAP_EX1_IR : TAP_SH_IR;
            TAP_EX1_IR: nxt_state = tms_sync_ff[1] ? TAP_UPD_IR : TAP_PAU_IR;
            TAP_PAU_IR: nxt_state = tms_sync_ff[1] ? TAP_EX2_IR : TAP_PAU_IR;
            TAP_EX2_IR: nxt_state = tms_sync_ff[1] ? TAP_UPD_IR : TAP_SH_IR;
            TAP_UPD_IR: nxt_state = tms_sync_ff[1] ? TAP_SEL_DR : TAP_IDLE;
            default: nxt_state = TAP_RESET;
        endcase
    end

    // The state advances only on a detected rising test clock edge.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            state_ff <= TAP_RESET;
        end else if (tck_rise) begin
            state_ff <= nxt_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Instruction register.
    ////////////////////////////////////////////////////////////////////////

    logic [IR_LEN-1:0] ir_shift_ff; // Instruction shift stage.
    logic [IR_LEN-1:0] ir_ff; // Active instruction.

    // Capture, shift toward bit zero, and update the instruction.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ir_shift_ff <= IR_CAPTURE;
            ir_ff <= OP_DEVICE_IDENTIFICATION_WORD;
        end else if (tck_rise) begin
            case (state_ff)
                TAP_RESET: begin
                    ir_ff <= OP_DEVICE_IDENTIFICATION_WORD;
                end
                TAP_CAP_IR: begin
                    ir_shift_ff <= IR_CAPTURE;
                end
                TAP_SH_IR: begin
                    ir_shift_ff <= {tdi_sync_ff[1], ir_shift_ff[IR_LEN-1:1]};
                end
                TAP_UPD_IR: begin
                    ir_ff <= ir_shift_ff;
                end
                default: begin
                    ir_ff <= ir_ff;
                end
            endcase
        end
    end

    // Instructions that route through the 32-bit data register.
    function automatic logic is_wide(input logic [IR_LEN-1:0] op);
        is_wide = (op == OP_DEVICE_IDENTIFICATION_WORD) || (op == OP_CFG_READ) ||
                  (op == OP_CFG_PROG) || (op == OP_CFG_SECURE) ||
                  (op == OP_CFG_ERASE);
    endfunction

    // Every other code, including external test and sample, selects bypass.
    logic sel_bypass; // High when the one-bit path is active.
    assign sel_bypass = !is_wide(ir_ff);

    ////////////////////////////////////////////////////////////////////////
    // Data register path.
    ////////////////////////////////////////////////////////////////////////

    logic [ID_LEN-1:0] id_word; // Fixed identification word.
    logic [ID_LEN-1:0] dr_ff; // Data shift stage; bit zero faces output.
    logic [ID_LEN-1:0] cap_val; // Value loaded in the capture state.

    // Fields are placed most significant first, fixed one at bit zero.
    assign id_word = {VERSION, PART, MFR, ID_FIXED_BIT};

    // Choose the capture value; a secured part reads its configuration as zeros.
    always_comb begin
        cap_val = {ID_LEN{1'b0}};
        if (ir_ff == OP_DEVICE_IDENTIFICATION_WORD) begin
            cap_val = id_word;
        end else if (ir_ff == OP_CFG_READ) begin
            cap_val = secure_ff ? {ID_LEN{1'b0}} : cfg_ff;
        end
    end

    // Capture and shift; bypass uses bit zero alone with zeros above.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dr_ff <= {ID_LEN{1'b0}};
        end else if (tck_rise) begin
            if (state_ff == TAP_CAP_DR) begin
                dr_ff <= sel_bypass ? {ID_LEN{1'b0}} : cap_val;
            end else if (state_ff == TAP_SH_DR) begin
                if (sel_bypass) begin
                    dr_ff <= {{(ID_LEN-1){1'b0}}, tdi_sync_ff[1]};
                end else begin
                    dr_ff <= {tdi_sync_ff[1], dr_ff[ID_LEN-1:1]};
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Stored configuration and security bit.
    ////////////////////////////////////////////////////////////////////////

    logic upd_dr; // Pulse on the rise leaving the update state.
    assign upd_dr = tck_rise && (state_ff == TAP_UPD_DR);

    // Programming only adds bits; only an erase clears word and lock.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_ff <= CFG_BLANK;
            secure_ff <= 1'b0;
        end else if (upd_dr) begin
            if (ir_ff == OP_CFG_ERASE) begin
                cfg_ff <= CFG_BLANK;
                secure_ff <= 1'b0;
            end else if (ir_ff == OP_CFG_PROG) begin
                cfg_ff <= cfg_ff | dr_ff;
            end else if (ir_ff == OP_CFG_SECURE) begin
                secure_ff <= secure_ff | dr_ff[0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Serial output, changed on the falling test clock edge.
    ////////////////////////////////////////////////////////////////////////

    // Output bit zero of the active path; drive only while shifting.
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            tdo <= 1'b0;
            tdo_oe_n <= 1'b1;
        end else if (tck_fall) begin
            if (state_ff == TAP_SH_IR) begin
                tdo <= ir_shift_ff[0];
                tdo_oe_n <= 1'b0;
            end else if (state_ff == TAP_SH_DR) begin
                tdo <= dr_ff[0];
                tdo_oe_n <= 1'b0;
            end else begin
                tdo_oe_n <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks.
    ////////////////////////////////////////////////////////////////////////

    bypass_variant_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_SH_DR &&
        (ir_ff == OP_EXTEST || ir_ff == OP_SAMPLE)
        |=> dr_ff == {{(ID_LEN-1){1'b0}}, $past(tdi_sync_ff[1])})
        else $error("External test or sample did not use bypass bit.");

    id_fields_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_CAP_DR && ir_ff == OP_DEVICE_IDENTIFICATION_WORD
        |=> dr_ff[ID_LEN-1:ID_VER_LSB] == VERSION &&
            dr_ff[ID_PART_LSB+ID_PART_W-1:ID_PART_LSB] == PART &&
            dr_ff[ID_MFR_LSB+ID_MFR_W-1:ID_MFR_LSB] == MFR)
        else $error("Identification fields captured wrongly.");

    id_lsb_one_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_CAP_DR && ir_ff == OP_DEVICE_IDENTIFICATION_WORD
        |=> dr_ff[0] == 1'b1)
        else $error("Identification bit zero not one.");

    id_msb_order_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_CAP_DR && ir_ff == OP_DEVICE_IDENTIFICATION_WORD
        |=> dr_ff[ID_LEN-1] == VERSION[ID_VER_W-1])
        else $error("Version top bit not at word top.");

    secure_read_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_CAP_DR && ir_ff == OP_CFG_READ &&
        secure_ff |=> dr_ff == {ID_LEN{1'b0}})
        else $error("Secured configuration was read out.");

    lock_hold_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        $fell(secure_ff) |-> $past(upd_dr) && $past(ir_ff) == OP_CFG_ERASE)
        else $error("Security bit cleared without erase.");

    ir_update_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_UPD_IR |=> ir_ff == $past(ir_shift_ff))
        else $error("Instruction not updated from shift stage.");

    id_out_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_fall && state_ff == TAP_SH_DR
        |=> tdo == $past(dr_ff[0]) && !tdo_oe_n)
        else $error("Data output not driven from data path.");

    bypass_cap_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_CAP_DR && ir_ff == OP_BYPASS
        |=> dr_ff == {ID_LEN{1'b0}})
        else $error("Bypass bit did not capture zero.");

    id_shift_a: assert property (
        @(posedge sys_clk) disable iff (!rst_n)
        tck_rise && state_ff == TAP_SH_DR && ir_ff == OP_DEVICE_IDENTIFICATION_WORD
        |=> dr_ff[ID_LEN-2:0] == $past(dr_ff[ID_LEN-1:1]))
        else $error("Identification word not shifted toward bit zero.");

endmodule

// ==== testbench/jidb_ctrl_model.sv ====
/*
 * Behavioural model of the external scan controller that drives the
 * four-wire test port and reads back each shifted word.
 * Assumes it shares sys_clk with the bench and that every scan starts
 * and ends in Run-Test/Idle.
 */
`timescale 1ns/1ps
module jidb_ctrl_model (
    input wire logic sys_clk,
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo,
    input wire logic tdo_oe_n,
    output logic [31:0] rx_word,
    output logic rx_oe_ok,
    output logic rx_valid
);
    // Cleared when the output enable disagrees with the shift phase.
    logic oe_ok;

    // The test clock rests high between scans.
    initial begin
        tck = 1'b1;
        tms = 1'b1;
        tdi = 1'b0;
        rx_word = 32'h0000_0000;
        rx_oe_ok = 1'b0;
        rx_valid = 1'b0;
        oe_ok = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // One test clock of 80 ns: inputs change at the fall, held over rise.
    task automatic tick(input logic m, input logic d, input logic sh,
                        output logic q);
        @(posedge sys_clk);
        tck <= 1'b0;
        tms <= m;
        tdi <= d;
        repeat (8) @(posedge sys_clk);
        // A released data output floats to its pull-up level.
        q = tdo_oe_n ? 1'b1 : tdo;
        if (tdo_oe_n !== !sh) begin
            oe_ok = 1'b0;
        end
        tck <= 1'b1;
        repeat (7) @(posedge sys_clk);
    endtask

    // Five clocks with mode high reach Test-Logic-Reset, then Idle.
    task automatic goto_idle();
        logic q;
        repeat (5) tick(1'b1, 1'b0, 1'b0, q);
        tick(1'b0, 1'b0, 1'b0, q);
    endtask

    // Full instruction or data scan; data enters and leaves LSB first.
    task automatic scan(input logic is_ir, input int len,
                        input logic [31:0] din);
        logic [31:0] got;
        logic q;
        got = 32'h0000_0000;
        oe_ok = 1'b1;
        tick(1'b1, 1'b0, 1'b0, q);
        if (is_ir) begin
            tick(1'b1, 1'b0, 1'b0, q);
        end
        tick(1'b0, 1'b0, 1'b0, q);
        tick(1'b0, 1'b0, 1'b0, q);
        // Exactly len bits per scan, ten for an instruction.
        for (int i = 0; i < len; i++) begin
            tick(i == len - 1, din[i], 1'b1, q);
            got[i] = q;
        end
        // Data input toggles outside shifting, so stale bits never pass.
        tick(1'b1, ~din[len-1], 1'b0, q);
        tick(1'b0, din[len-1], 1'b0, q);
        rx_word <= got;
        rx_oe_ok <= oe_ok;
        rx_valid <= 1'b1;
        @(posedge sys_clk);
        rx_valid <= 1'b0;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
/*
 * Self-checking bench for the identification, bypass and security block.
 * Assumes the design package is compiled first and the controller model
 * is available as a separate module.
 */
`timescale 1ns/1ps
module tb_top;
    import jidb_pkg::*;

    // Identity values handed to the design; the values are arbitrary.
    localparam logic [3:0] T_VER = 4'h6;
    localparam logic [15:0] T_PART = 16'h3C5A;
    localparam logic [10:0] T_MFR = 11'h1D3;
    localparam logic [31:0] ID_WORD = {T_VER, T_PART, T_MFR, 1'b1};

    logic sys_clk;
    logic rst_n;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;
    logic tdo_oe_n;
    logic secure_ff;
    logic [31:0] cfg_ff;
    logic [31:0] rx_word;
    logic rx_oe_ok;
    logic rx_valid;
    int n_mismatch;
    int n_checks;
    int seed;
    logic [31:0] d;
    logic [IR_LEN-1:0] byp_ops [4];
    // Notes hold {care, enable ok, word} for each scan still in flight.
    logic [33:0] exp_q [$];

    jidb_top #(.VERSION(T_VER), .PART(T_PART), .MFR(T_MFR)) dut (
        .sys_clk(sys_clk), .rst_n(rst_n), .tck(tck), .tms(tms),
        .tdi(tdi), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
        .secure_ff(secure_ff), .cfg_ff(cfg_ff));

    jidb_ctrl_model ctrl (
        .sys_clk(sys_clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo),
        .tdo_oe_n(tdo_oe_n), .rx_word(rx_word), .rx_oe_ok(rx_oe_ok),
        .rx_valid(rx_valid));

    // System clock of 200 MHz.
    initial sys_clk = 1'b0;
    always #2.5 sys_clk = ~sys_clk;

    ////////////////////////////////////////////////////////////////////////
    // Reporting helpers.
    task automatic give_verdict();
        $display("Checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compares a word read back through the port with its note.
    task automatic chk_scan(input logic [32:0] e, input logic [32:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR scan word expected %h got %h", e, g);
        end
    endtask

    // Compares a stored level seen at the design outputs.
    task automatic chk_lvl(input string nm, input logic [31:0] e,
                           input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR %s expected %h got %h", nm, e, g);
        end
    endtask

    // Notes the expected result, then runs the scan.
    task automatic run(input logic ir, input int len,
                       input logic [31:0] din, input logic [33:0] note);
        exp_q.push_back(note);
        ctrl.scan(ir, len, din);
    endtask

    ////////////////////////////////////////////////////////////////////////
    // Watcher: each finished scan consumes the oldest note.
    always @(posedge sys_clk) begin
        if (rx_valid === 1'b1) begin
            if (exp_q.size() == 0) begin
                n_mismatch++;
                $display("ERROR scan note expected 1 got 0");
            end else if (exp_q[0][33]) begin
                chk_scan(exp_q[0][32:0], {rx_oe_ok, rx_word});
                void'(exp_q.pop_front());
            end else begin
                void'(exp_q.pop_front());
            end
        end
    end

    // A hang counts as a mismatch and ends the run.
    initial begin
        repeat (60000) @(posedge sys_clk);
        n_mismatch++;
        $display("ERROR timeout expected done got hang");
        give_verdict();
    end

    ////////////////////////////////////////////////////////////////////////
    // Main sequence.
    initial begin
        n_mismatch = 0;
        n_checks = 0;
        seed = 97;
        rst_n = 1'b0;
        byp_ops = '{OP_EXTEST, OP_SAMPLE, OP_BYPASS, 10'h2AA};
        repeat (8) @(posedge sys_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk_lvl("secure", 32'h0, {31'h0, secure_ff});
        ctrl.goto_idle();
        run(1'b0, 32, $random(seed), {2'b11, ID_WORD});
        $display("Test identify after reset done");
        // Bypass family, each after checking the instruction capture.
        for (int k = 0; k < 4; k++) begin
            d = $random(seed);
            run(1'b1, 10, {22'h0, byp_ops[k]}, {2'b11, 32'h1});
            run(1'b0, 32, d, {2'b11, d[30:0], 1'b0});
        end
        $display("Test bypass paths done");
        run(1'b1, 10, {22'h0, OP_DEVICE_IDENTIFICATION_WORD}, {2'b11, 32'h1});
        run(1'b0, 32, $random(seed), {2'b11, ID_WORD});
        $display("Test identify instruction done");
        // Program a random word, read it back, then lock the part.
        d = $random(seed);
        run(1'b1, 10, {22'h0, OP_CFG_PROG}, {2'b11, 32'h1});
        run(1'b0, 32, d, 34'h0);
        chk_lvl("cfg", d, cfg_ff);
        run(1'b1, 10, {22'h0, OP_CFG_READ}, {2'b11, 32'h1});
        run(1'b0, 32, ~d, {2'b11, d});
        run(1'b1, 10, {22'h0, OP_CFG_SECURE}, {2'b11, 32'h1});
        run(1'b0, 32, 32'h1, 34'h0);
        chk_lvl("secure", 32'h1, {31'h0, secure_ff});
        run(1'b1, 10, {22'h0, OP_CFG_READ}, {2'b11, 32'h1});
        run(1'b0, 32, d, {2'b11, 32'h0});
        chk_lvl("cfg", d, cfg_ff);
        ctrl.goto_idle();
        chk_lvl("secure", 32'h1, {31'h0, secure_ff});
        run(1'b0, 32, d, {2'b11, ID_WORD});
        $display("Test security lock done");
        // Only a full erase clears the lock and the stored word.
        run(1'b1, 10, {22'h0, OP_CFG_ERASE}, {2'b11, 32'h1});
        run(1'b0, 32, d, 34'h0);
        chk_lvl("secure", 32'h0, {31'h0, secure_ff});
        chk_lvl("cfg", CFG_BLANK, cfg_ff);
        $display("Test erase done");
        repeat (4) @(posedge sys_clk);
        chk_lvl("pending notes", 32'h0, exp_q.size());
        give_verdict();
    end
endmodule
